// ===== srsc_pkg.sv
// constants, register map and carrier types for the s/pdif receiver status block
// assumes a 100 MHz pclk and a front end that delivers decoded sub-frames on pclk
package srsc_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_FLAGS = 6'h01;
   localparam logic [5:0] IDX_INT_STAT = 6'h02;
   localparam logic [5:0] IDX_INT_MASK = 6'h03;
   localparam logic [5:0] IDX_RATE_ACC = 6'h10;
   localparam logic [5:0] IDX_WL_ORIG = 6'h11;

   // ****************************************************************
   // control register fields
   // ****************************************************************
   localparam int CTRL_WORD_LENGTH_MASK = 0;
   localparam int CTRL_GPO0_LSB = 1;
   localparam int CTRL_GPO1_LSB = 4;
   localparam int NUM_GPO = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ****************************************************************
   // flag layout, shared by flags, interrupt status and mask
   // ****************************************************************
   localparam int FL_UNLOCK = 0;
   localparam int FL_INVALID = 1;
   localparam int FL_LINK_ERR = 2;
   localparam int FL_PCM_ABSENT = 3;
   localparam int FL_ENCODED = 4;
   localparam int FL_NON_AUDIO = 5;
   localparam int FL_SILENCE = 6;
   localparam int FL_UPDATE = 7;
   localparam logic [7:0] EDGE_ANY_MASK = 8'h21;

   // ****************************************************************
   // channel status layout
   // ****************************************************************
   localparam logic [7:0] CS_LEN = 8'h28;
   localparam int CS_PCM_ABSENT = 1;
   localparam int CS_RATE_LSB = 24;
   localparam int CS_MAXLEN = 32;
   localparam int CS_WL_LSB = 33;
   localparam logic [39:0] CS_RESET = 40'h0131000000;
   localparam logic [7:0] LAST_FRAME = 8'hbf;

   // ****************************************************************
   // stream detectors
   // ****************************************************************
   localparam logic [10:0] SILENCE_FRAMES = 11'h400;
   localparam logic [12:0] ENC_HOLD_FRAMES = 13'h1000;
   localparam logic [15:0] SYNC_PA = 16'hf872;
   localparam logic [15:0] SYNC_PB = 16'h4e1f;
   localparam logic [4:0] FULL_WIDTH = 5'h18;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic strobe;
      logic chan_b;
      logic [23:0] audio;
      logic validity;
      logic cs_bit;
      logic block_start;
      logic preamble_err;
      logic parity_err;
      logic biphase_err;
   } srsc_subframe_s;

   typedef struct packed {
      logic strobe;
      logic chan_b;
      logic [23:0] sample;
   } srsc_audio_s;

endpackage

// ===== srsc_silence_detect.sv
// consecutive all-zero frame counter driving the silence flag
// assumes one frame_done pulse per frame, on the same clock
`timescale 1ns/1ps
module srsc_silence_detect (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // frame results
   input wire logic frame_done,
   input wire logic frame_zero,
   // flag
   output logic silence_q
);

   logic [10:0] count_q;

   // saturate so a long silence never wraps back to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 11'h000;
      end else if (frame_done) begin
         if (!frame_zero) begin
            count_q <= 11'h000;
         end else if (count_q != srsc_pkg::SILENCE_FRAMES) begin
            count_q <= count_q + 11'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         silence_q <= 1'b0;
      end else if (frame_done) begin
         silence_q <= frame_zero && (count_q >= srsc_pkg::SILENCE_FRAMES - 11'h001);
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_silence_count;
      @(posedge pclk) disable iff (!presetn)
      $rose(silence_q) |-> $past(count_q) == 11'h3ff;
   endproperty
   a_silence_count: assert property (p_silence_count) else $error("silence rose early");

   property p_silence_restart;
      @(posedge pclk) disable iff (!presetn)
      frame_done && !frame_zero |=> !silence_q && count_q == 11'h000;
   endproperty
   a_silence_restart: assert property (p_silence_restart) else $error("silence not cleared");

   c_silence: cover property (@(posedge pclk) disable iff (!presetn) $rose(silence_q));

endmodule // srsc_silence_detect

// ===== srsc_status_capture.sv
// s/pdif receiver status capture: channel status registers, truncation, flags
// assumes decoded sub-frames on pclk and an asynchronous lock level from clock recovery
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module srsc_status_capture (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receiver front end
   input wire srsc_pkg::srsc_subframe_s rx_sf,
   input wire logic recovery_locked,
   // audio data interface
   output srsc_pkg::srsc_audio_s aud_out,
   // pins
   output logic [1:0] general_output_pin,
   output logic irq
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic lock_meta_q, lock_sync_q;
   logic [7:0] ctrl_q, int_stat_q, int_mask_q, flags_prev_q, prdata_q;
   logic [7:0] flags;
   logic [39:0] cs_work_q, cs_stored_q;
   logic [7:0] frame_q;
   logic in_block_q;
   logic unlock_q, invalid_q, link_err_q, encoded_q, update_q;
   logic pa_hit_q, zero_a_q;
   logic [12:0] enc_idle_q;
   logic silence;
   logic sf_a, cs_last, cs_differs, cs_bit_mismatch, cs_read, wr_go;
   logic [5:0] idx;
   logic addr_hit;
   logic [7:0] rd_mux, int_ev;
   logic [4:0] word_len;
   logic [23:0] keep_mask;
   logic frame_done, frame_zero;
   logic word_length_mask, max_length_select, pcm_absent, non_audio;
   logic [2:0] word_length_code;
   logic [3:0] indicated_sample_rate, original_sample_rate;
   logic [1:0] clock_accuracy_level;

   // ****************************************************************
   // lock synchroniser and per-sub-frame flags
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_meta_q <= 1'b0;
         lock_sync_q <= 1'b0;
      end else begin
         lock_meta_q <= recovery_locked;
         lock_sync_q <= lock_meta_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q <= 1'b1;
      end else begin
         unlock_q <= !lock_sync_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         invalid_q <= 1'b0;
         link_err_q <= 1'b0;
      end else if (rx_sf.strobe) begin
         invalid_q <= rx_sf.validity;
         link_err_q <= rx_sf.preamble_err | rx_sf.parity_err | rx_sf.biphase_err;
      end
   end

   // ****************************************************************
   // channel status capture, first channel only
   // ****************************************************************
   localparam logic [7:0] LAST_FRAME_M1 = srsc_pkg::LAST_FRAME - 8'h01;

   assign sf_a = rx_sf.strobe && !rx_sf.chan_b;
   assign cs_last = sf_a && in_block_q && !rx_sf.block_start && frame_q == LAST_FRAME_M1;
   // bit 39 was taken at frame 39; the bit seen at frame 191 is outside the window
   assign cs_differs = cs_work_q != cs_stored_q;
   assign cs_bit_mismatch = sf_a && rx_sf.block_start ? rx_sf.cs_bit != cs_stored_q[0]
                          : sf_a && in_block_q && (frame_q + 8'h01) < srsc_pkg::CS_LEN
                            && rx_sf.cs_bit != cs_stored_q[6'(frame_q + 8'h01)];

   // frame_q holds the index of the last first-channel sub-frame taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_q <= 8'h00;
         in_block_q <= 1'b0;
      end else if (!lock_sync_q) begin
         in_block_q <= 1'b0;
      end else if (sf_a) begin
         if (rx_sf.block_start) begin
            frame_q <= 8'h00;
            in_block_q <= 1'b1;
         end else if (in_block_q) begin
            frame_q <= frame_q + 8'h01;
            in_block_q <= frame_q != srsc_pkg::LAST_FRAME;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_work_q <= 40'h0000000000;
      end else if (sf_a && rx_sf.block_start) begin
         cs_work_q[0] <= rx_sf.cs_bit;
      end else if (sf_a && in_block_q && (frame_q + 8'h01) < srsc_pkg::CS_LEN) begin
         cs_work_q[6'(frame_q + 8'h01)] <= rx_sf.cs_bit;
      end
   end

   // stored copy only moves at block end, so software never sees a half block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_stored_q <= srsc_pkg::CS_RESET;
      end else if (cs_last && cs_differs) begin
         cs_stored_q <= cs_work_q;
      end
   end

   // set wins over a read in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         update_q <= 1'b0;
      end else if (cs_last && cs_differs) begin
         update_q <= 1'b1;
      end else if (cs_read || cs_bit_mismatch) begin
         update_q <= 1'b0;
      end
   end

   assign indicated_sample_rate = cs_stored_q[27:24];
   assign clock_accuracy_level = cs_stored_q[29:28];
   assign max_length_select = cs_stored_q[srsc_pkg::CS_MAXLEN];
   assign word_length_code = cs_stored_q[35:33];
   assign original_sample_rate = cs_stored_q[39:36];
   assign pcm_absent = cs_stored_q[srsc_pkg::CS_PCM_ABSENT];

   // ****************************************************************
   // word length decode and truncation
   // ****************************************************************
   always_comb begin
      word_len = 5'h00;
      unique case (word_length_code)
         3'b001: word_len = 5'h14;
         3'b010: word_len = 5'h16;
         3'b100: word_len = 5'h17;
         3'b101: word_len = 5'h18;
         3'b110: word_len = 5'h15;
         default: word_len = 5'h00;
      endcase
      if (word_len != 5'h00 && !max_length_select) begin
         word_len = word_len - 5'h04;
      end
   end

   // an unindicated length keeps the full word rather than guessing
   always_comb begin
      keep_mask = 24'hffffff;
      if (word_len != 5'h00 && !word_length_mask) begin
         keep_mask = ~((24'h000001 << (srsc_pkg::FULL_WIDTH - word_len)) - 24'h000001);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aud_out <= '0;
      end else begin
         aud_out.strobe <= rx_sf.strobe;
         if (rx_sf.strobe) begin
            aud_out.chan_b <= rx_sf.chan_b;
            aud_out.sample <= rx_sf.audio & keep_mask;
         end
      end
   end

   // ****************************************************************
   // burst sync and silence detection
   // ****************************************************************
   assign frame_done = rx_sf.strobe && rx_sf.chan_b;
   assign frame_zero = zero_a_q && rx_sf.audio == 24'h000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_hit_q <= 1'b0;
         zero_a_q <= 1'b0;
      end else if (sf_a) begin
         pa_hit_q <= rx_sf.audio[23:8] == srsc_pkg::SYNC_PA;
         zero_a_q <= rx_sf.audio == 24'h000000;
      end
   end

   // the flag holds across the gaps between bursts, then times out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         encoded_q <= 1'b0;
         enc_idle_q <= 13'h0000;
      end else if (frame_done) begin
         if (pa_hit_q && rx_sf.audio[23:8] == srsc_pkg::SYNC_PB) begin
            encoded_q <= 1'b1;
            enc_idle_q <= 13'h0000;
         end else if (enc_idle_q == srsc_pkg::ENC_HOLD_FRAMES) begin
            encoded_q <= 1'b0;
         end else begin
            enc_idle_q <= enc_idle_q + 13'h0001;
         end
      end
   end

   srsc_silence_detect u_silence (
      .pclk(pclk),
      .presetn(presetn),
      .frame_done(frame_done),
      .frame_zero(frame_zero),
      .silence_q(silence)
   );

   // ****************************************************************
   // flags, interrupt and output pins
   // ****************************************************************
   assign non_audio = encoded_q | pcm_absent;
   assign flags = {update_q, silence, non_audio, encoded_q, pcm_absent,
                   link_err_q, invalid_q, unlock_q};
   assign int_ev = (flags & ~flags_prev_q) | ((flags ^ flags_prev_q) & srsc_pkg::EDGE_ANY_MASK);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_prev_q <= 8'h01;
         int_stat_q <= 8'h00;
      end else begin
         flags_prev_q <= flags;
         if (wr_go && idx == srsc_pkg::IDX_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[7:0]) | int_ev;
         end else begin
            int_stat_q <= int_stat_q | int_ev;
         end
      end
   end

   assign irq = |(int_stat_q & int_mask_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_output_pin <= 2'b00;
      end else begin
         general_output_pin[0] <= flags[ctrl_q[3:1]];
         general_output_pin[1] <= flags[ctrl_q[6:4]];
      end
   end

   // ****************************************************************
   // apb slave, zero wait, read data captured in the setup cycle
   // ****************************************************************
   assign idx = paddr[7:2];
   assign addr_hit = idx == srsc_pkg::IDX_CTRL || idx == srsc_pkg::IDX_FLAGS
                  || idx == srsc_pkg::IDX_INT_STAT || idx == srsc_pkg::IDX_INT_MASK
                  || idx == srsc_pkg::IDX_RATE_ACC || idx == srsc_pkg::IDX_WL_ORIG;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign prdata = {24'h000000, prdata_q};
   assign wr_go = psel && penable && pwrite && addr_hit;
   assign cs_read = psel && penable && !pwrite
                 && (idx == srsc_pkg::IDX_RATE_ACC || idx == srsc_pkg::IDX_WL_ORIG);
   assign word_length_mask = ctrl_q[srsc_pkg::CTRL_WORD_LENGTH_MASK];

   always_comb begin
      rd_mux = 8'h00;
      unique case (idx)
         srsc_pkg::IDX_CTRL: rd_mux = ctrl_q;
         srsc_pkg::IDX_FLAGS: rd_mux = flags;
         srsc_pkg::IDX_INT_STAT: rd_mux = int_stat_q;
         srsc_pkg::IDX_INT_MASK: rd_mux = int_mask_q;
         srsc_pkg::IDX_RATE_ACC: rd_mux = {2'b00, clock_accuracy_level, indicated_sample_rate};
         srsc_pkg::IDX_WL_ORIG: rd_mux = {original_sample_rate, word_length_code,
                                          max_length_select};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 8'h00;
      end else if (psel && !penable) begin
         prdata_q <= pwrite ? 8'h00 : rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= srsc_pkg::CTRL_RESET;
         int_mask_q <= 8'h00;
      end else if (wr_go) begin
         if (idx == srsc_pkg::IDX_CTRL) begin
            ctrl_q <= {1'b0, pwdata[6:0]};
         end
         if (idx == srsc_pkg::IDX_INT_MASK) begin
            int_mask_q <= pwdata[7:0];
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_unlock;
      @(posedge pclk) disable iff (!presetn)
      unlock_q == !$past(lock_sync_q);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock not raised");

   property p_invalid;
      @(posedge pclk) disable iff (!presetn)
      rx_sf.strobe |=> invalid_q == $past(rx_sf.validity);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid flag wrong");

   property p_link_err;
      @(posedge pclk) disable iff (!presetn)
      rx_sf.strobe |=> link_err_q == ($past(rx_sf.preamble_err) || $past(rx_sf.parity_err)
                                      || $past(rx_sf.biphase_err));
   endproperty
   a_link_err: assert property (p_link_err) else $error("link error flag wrong");

   property p_trunc;
      @(posedge pclk) disable iff (!presetn)
      rx_sf.strobe && !word_length_mask && word_length_code == 3'b001 && max_length_select
      |=> aud_out.strobe && aud_out.sample[3:0] == 4'h0
          && aud_out.sample[23:4] == $past(rx_sf.audio[23:4]);
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncation to 20 bits wrong");

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      rx_sf.strobe && word_length_mask |=> aud_out.sample == $past(rx_sf.audio);
   endproperty
   a_bypass: assert property (p_bypass) else $error("mask did not bypass");

   property p_update_set;
      @(posedge pclk) disable iff (!presetn)
      $rose(update_q) |-> $past(cs_last) && cs_stored_q[29:24] != $past(cs_stored_q[29:24])
                          || $past(cs_last) && cs_stored_q != $past(cs_stored_q);
   endproperty
   a_update_set: assert property (p_update_set) else $error("update without block end");

   property p_update_clear;
      @(posedge pclk) disable iff (!presetn)
      cs_read && !(cs_last && cs_differs) |=> !update_q;
   endproperty
   a_update_clear: assert property (p_update_clear) else $error("read did not clear");

   property p_non_audio;
      @(posedge pclk) disable iff (!presetn)
      $rose(encoded_q) |-> flags[srsc_pkg::FL_NON_AUDIO] ##1 int_stat_q[srsc_pkg::FL_NON_AUDIO];
   endproperty
   a_non_audio: assert property (p_non_audio) else $error("non-audio not raised");

   property p_pcm_absent;
      @(posedge pclk) disable iff (!presetn)
      cs_last && cs_differs |=> flags[srsc_pkg::FL_PCM_ABSENT] == $past(cs_work_q[1]);
   endproperty
   a_pcm_absent: assert property (p_pcm_absent) else $error("pcm absent wrong");

   c_update: cover property (@(posedge pclk) disable iff (!presetn) $rose(update_q));
   c_encoded: cover property (@(posedge pclk) disable iff (!presetn) $rose(encoded_q));
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule // srsc_status_capture

// ===== srsc_spdif_src.sv
// s/pdif source model: one A and one B sub-frame per four pclk cycles
// assumes the bench sets cs_vec per block and calls send() once per frame
`timescale 1ns/1ps
module srsc_spdif_src (
   // clock
   input wire logic pclk,
   // decoded sub-frames
   output srsc_pkg::srsc_subframe_s rx_sf
);
   logic [39:0] cs_vec = 40'h0;
   int n = 0;
   logic cs_now;
   initial rx_sf = '0;
   // idle cycles carry inverted fields so stale values are never trusted
   task send(input logic [23:0] a, input logic [23:0] b, input logic v, input logic [2:0] e);
      // bits past the 40 captured ones are sent as zero on A and one on B, never unknown
      cs_now = (n < 40) ? cs_vec[n] : 1'b0;
      @(posedge pclk) rx_sf <= {2'b10, a, v, cs_now, n == 0, e};
      @(posedge pclk) rx_sf <= {2'b00, ~a, ~v, 2'b00, ~e};
      @(posedge pclk) rx_sf <= {2'b11, b, v, ~cs_now, 1'b0, e};
      @(posedge pclk) rx_sf <= {2'b01, ~b, ~v, 2'b00, ~e};
      n = (n == 191) ? 0 : n + 1;
   endtask
endmodule // srsc_spdif_src

// ===== srsc_status_capture_tb.sv
// self-checking bench for the receiver status block, apb master and model
// assumes srsc_spdif_src feeds rx_sf and a 100 MHz pclk
`timescale 1ns/1ps
module srsc_status_capture_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, recovery_locked = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'd83342;
   logic pready, pslverr, irq, slv, msk = 0;
   logic [1:0] general_output_pin;
   srsc_pkg::srsc_subframe_s rx_sf;
   srsc_pkg::srsc_audio_s aud_out;
   logic [39:0] cs, st = srsc_pkg::CS_RESET;
   logic [25:0] exp_q[$], x;
   int lens[16] = '{24, 16, 18, 24, 19, 20, 17, 24, 24, 20, 22, 24, 23, 24, 21, 24};
   int n_fail = 0, n_compared = 0;
   always #5 pclk = ~pclk;
   srsc_status_capture dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rx_sf, .recovery_locked, .aud_out, .general_output_pin, .irq);
   srsc_spdif_src src (.pclk, .rx_sf);
   // ****************************************************************
   // helpers
   // ****************************************************************
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // reserved codes keep the full word, as the designer chose
   function automatic logic [23:0] trunc(input logic [23:0] s);
      if (msk) return s;
      return s & (24'hffffff << (24 - lens[{st[32], st[35:33]}]));
   endfunction
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         conclude;
      end else begin
         r = prdata;
         slv = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   task frame(input logic [23:0] a, input logic [23:0] b, input logic v, input logic [2:0] e,
              input logic en);
      exp_q.push_back({en, 1'b0, trunc(a)});
      exp_q.push_back({en, 1'b1, trunc(b)});
      src.send(a, b, v, e);
   endtask
   task chk_cs;
      apb(1'b0, 8'h40, 32'h0);
      chk(r, {26'h0, st[29:24]});
      apb(1'b0, 8'h44, 32'h0);
      chk(r, {24'h0, st[39:32]});
   endtask
   always @(posedge pclk)
      if (aud_out.strobe === 1'b1) begin
         x = exp_q.pop_front();
         if (x[25]) chk({aud_out.chan_b, aud_out.sample}, x[24:0]);
      end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      int k, j;
      logic upd;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_cs;
      apb(1'b0, 8'h20, 32'h0);
      chk({r[30:0], slv}, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(r[0], 1);
      chk(general_output_pin[0], 1);
      recovery_locked <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk(r[0], 0);
      chk(general_output_pin[0], 0);
      // each block loads the next word length code, the following one checks it
      for (k = 0; k < 17; k++) begin
         if (k < 16) cs = {8'h0, nxt()} ^ {nxt(), 8'h0};
         if (k < 16) cs[35:32] = {k[2:0], k[3]};
         if (k == 16) msk = 1'b1;
         if (k == 16) apb(1'b1, 8'h00, 32'h61);
         src.cs_vec = cs;
         for (j = 0; j < 192; j++) frame(24'(nxt()), 24'(nxt()), 1'b0, 3'h0, j != 191);
         upd = (cs !== st);
         st = cs;
         apb(1'b0, 8'h04, 32'h0);
         chk(r[7], upd);
         chk(r[5:3], {cs[1], 1'b0, cs[1]});
         chk_cs;
         apb(1'b0, 8'h04, 32'h0);
         chk(r[7], 0);
      end
      apb(1'b1, 8'h0c, 32'h4);
      for (k = 0; k < 4; k++) begin
         frame(24'h1, 24'h1, k == 3, (k < 3) ? 3'(1 << k) : 3'h0, 1'b1);
         apb(1'b0, 8'h04, 32'h0);
         chk(r[2:1], {k < 3, k == 3});
      end
      chk(irq, 1);
      apb(1'b1, 8'h08, 32'h4);
      @(negedge pclk);
      chk(irq, 0);
      for (j = 0; j < 1024; j++) begin
         if (j == 1023) apb(1'b0, 8'h04, 32'h0);
         if (j == 1023) chk(r[6], 0);
         frame(24'h0, 24'h0, 1'b0, 3'h0, 1'b1);
      end
      apb(1'b0, 8'h04, 32'h0);
      chk(r[6], 1);
      chk(general_output_pin[1], 1);
      frame(24'h100, 24'h0, 1'b0, 3'h0, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk(r[6], 0);
      chk(general_output_pin[1], 0);
      frame({srsc_pkg::SYNC_PA, 8'h0}, {srsc_pkg::SYNC_PB, 8'h0}, 1'b0, 3'h0, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk(r[5:4], 2'b11);
      conclude;
   end
endmodule // srsc_status_capture_tb
